/* File: frp_dev.sv */
// flash end: resume, suspend, power-down and id read commands
module frp_dev #(
  parameter logic [7:0] MFR_ID = 8'h5A, // arbitrary value
  parameter logic [7:0] DEV_ID = 8'h17 // arbitrary value
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  frp_if.dev LNK,
  input wire logic OP_START,
  input wire logic OP_DONE,
  input wire logic POWER_LOSS,
  output logic BUSY,
  output logic SUSPENDED,
  output logic POWER_DOWN,
  output logic SUSPEND_REQ,
  output logic RESUME_REQ
);
  typedef enum logic [2:0] {D_IDLE, D_CMD, D_DONE, D_HDR, D_OUT, D_IGN} frp_dst_t;
  typedef struct packed {
    frp_dst_t st;
    logic sclk_q;
    logic cs_q;
    logic [4:0] nbit;
    logic [7:0] cmd;
    logic a0;
    logic dev_sel;
    logic [7:0] osr;
    logic [3:0] obits;
    logic [3:0] dout;
    logic [3:0] doe_n;
    logic busy;
    logic suspend_status_flag;
    logic pd;
    logic pd_goal;
    logic [frp_pkg::TMR_W-1:0] pd_tmr;
    logic [frp_pkg::TMR_W-1:0] sus_tmr;
    logic sus_req;
    logic res_req;
  } frp_dstate_t;
  localparam frp_dstate_t D_RST = '{st: D_IDLE, cs_q: 1'b1, doe_n: frp_pkg::LANES_OFF,
                                    default: '0};
  frp_dstate_t s_ff;
  frp_dstate_t nxt_s;
  logic [5:0] sync_q;

  frp_sync #(.W(6), .RST_VAL(6'h10)) u_sync (
    .clk(SYS_CLK),
    .rst(RST),
    .d({LNK.sclk, LNK.cs_n, LNK.io}),
    .q(sync_q)
  );

  always_comb begin
    logic rise;
    logic fall;
    logic cs_rise;
    logic cs_fall;
    logic [3:0] w;
    logic [4:0] hdr_last;
    logic [4:0] a0_at;
    logic [7:0] cmd_nx;
    w = 4'h1;
    hdr_last = frp_pkg::HDR_LAST_SGL;
    a0_at = frp_pkg::HDR_LAST_SGL;
    nxt_s = s_ff;
    rise = sync_q[5] & ~s_ff.sclk_q;
    fall = ~sync_q[5] & s_ff.sclk_q;
    cs_rise = sync_q[4] & ~s_ff.cs_q;
    cs_fall = ~sync_q[4] & s_ff.cs_q;
    cmd_nx = {s_ff.cmd[6:0], sync_q[0]};
    nxt_s.sclk_q = sync_q[5];
    nxt_s.cs_q = sync_q[4];
    nxt_s.sus_req = 1'b0;
    nxt_s.res_req = 1'b0;
    case (s_ff.cmd)
      frp_pkg::OP_ID_DUAL: begin
        w = 4'h2;
        hdr_last = frp_pkg::HDR_LAST_DUAL;
        a0_at = frp_pkg::A0_AT_DUAL;
      end
      frp_pkg::OP_ID_QUAD: begin
        w = 4'h4;
        hdr_last = frp_pkg::HDR_LAST_QUAD;
        a0_at = frp_pkg::A0_AT_QUAD;
      end
      default: begin
      end
    endcase
    // self-timed suspend and power-state transitions
    if (s_ff.sus_tmr != '0) begin
      nxt_s.sus_tmr = s_ff.sus_tmr - 1'b1;
      if (nxt_s.sus_tmr == '0) begin
        nxt_s.busy = 1'b0;
      end
    end
    if (s_ff.pd_tmr != '0) begin
      nxt_s.pd_tmr = s_ff.pd_tmr - 1'b1;
      if (nxt_s.pd_tmr == '0) begin
        nxt_s.pd = s_ff.pd_goal;
      end
    end
    if (OP_DONE) begin
      nxt_s.busy = 1'b0;
    end
    if (OP_START) begin
      nxt_s.busy = 1'b1;
    end
    if (cs_fall) begin
      nxt_s.st = D_CMD;
      nxt_s.nbit = 5'h00;
    end else if (cs_rise) begin
      // only a frame that ended right after its eighth bit executes, or a release with trailing clocks
      if (s_ff.st == D_DONE) begin
        case (s_ff.cmd)
          frp_pkg::OP_RESUME: begin
            if (s_ff.suspend_status_flag && !s_ff.busy) begin
              nxt_s.suspend_status_flag = 1'b0;
              nxt_s.busy = 1'b1;
              nxt_s.res_req = 1'b1;
            end
          end
          frp_pkg::OP_SUSPEND: begin
            if (!s_ff.suspend_status_flag && s_ff.busy && s_ff.sus_tmr == '0) begin
              nxt_s.suspend_status_flag = 1'b1;
              nxt_s.sus_req = 1'b1;
              nxt_s.sus_tmr = frp_pkg::SUS_GUARD_CYC;
            end
          end
          frp_pkg::OP_PDOWN: begin
            nxt_s.pd_goal = 1'b1;
            nxt_s.pd_tmr = frp_pkg::PD_ENTER_CYC;
          end
          frp_pkg::OP_REL_ID: begin
            if (s_ff.pd) begin
              nxt_s.pd_goal = 1'b0;
              nxt_s.pd_tmr = frp_pkg::PD_EXIT_CYC;
            end
          end
          default: begin
          end
        endcase
      end
      nxt_s.st = D_IDLE;
      nxt_s.doe_n = frp_pkg::LANES_OFF;
    end else if (rise) begin
      case (s_ff.st)
        D_CMD: begin
          nxt_s.cmd = cmd_nx;
          nxt_s.nbit = s_ff.nbit + 5'h01;
          if (s_ff.nbit == 5'h07) begin
            nxt_s.nbit = 5'h00;
            nxt_s.st = D_IGN;
            if (s_ff.pd_tmr != '0) begin
              nxt_s.st = D_IGN;
            end else if (s_ff.pd) begin
              if (cmd_nx == frp_pkg::OP_REL_ID) begin
                nxt_s.st = D_DONE;
              end
            end else begin
              case (cmd_nx)
                frp_pkg::OP_RESUME, frp_pkg::OP_SUSPEND, frp_pkg::OP_PDOWN: begin
                  nxt_s.st = D_DONE;
                end
                frp_pkg::OP_REL_ID: begin
                  nxt_s.st = s_ff.busy ? D_IGN : D_HDR;
                end
                frp_pkg::OP_MFR_ID, frp_pkg::OP_ID_DUAL, frp_pkg::OP_ID_QUAD: begin
                  nxt_s.st = D_HDR;
                end
                default: begin
                  nxt_s.st = D_IGN;
                end
              endcase
            end
          end
        end
        D_DONE: begin
          // release with trailing id clocks still releases at select rise
          if (s_ff.cmd != frp_pkg::OP_REL_ID) begin
            nxt_s.st = D_IGN;
          end
        end
        D_HDR: begin
          nxt_s.nbit = s_ff.nbit + 5'h01;
          if (s_ff.nbit == a0_at) begin
            nxt_s.a0 = sync_q[0];
          end
          if (s_ff.nbit == hdr_last) begin
            nxt_s.st = D_OUT;
            nxt_s.obits = frp_pkg::BYTE_BITS;
            if (s_ff.cmd == frp_pkg::OP_REL_ID) begin
              nxt_s.dev_sel = 1'b1;
            end else begin
              nxt_s.dev_sel = (s_ff.nbit == a0_at) ? sync_q[0] : s_ff.a0;
            end
            nxt_s.osr = nxt_s.dev_sel ? DEV_ID : MFR_ID;
          end
        end
        default: begin
        end
      endcase
    end else if (fall && s_ff.st == D_OUT) begin
      case (w)
        4'h4: begin
          nxt_s.dout = s_ff.osr[7:4];
          nxt_s.doe_n = 4'h0;
        end
        4'h2: begin
          nxt_s.dout = {2'b00, s_ff.osr[7:6]};
          nxt_s.doe_n = 4'hC;
        end
        default: begin
          nxt_s.dout = {2'b00, s_ff.osr[7], 1'b0};
          nxt_s.doe_n = 4'hD;
        end
      endcase
      nxt_s.osr = 8'(s_ff.osr << w);
      nxt_s.obits = s_ff.obits - w;
      if (s_ff.obits == w) begin
        nxt_s.obits = frp_pkg::BYTE_BITS;
        nxt_s.dev_sel = (s_ff.cmd == frp_pkg::OP_REL_ID) | ~s_ff.dev_sel;
        nxt_s.osr = nxt_s.dev_sel ? DEV_ID : MFR_ID;
      end
    end
    if (POWER_LOSS) begin
      nxt_s.suspend_status_flag = 1'b0;
      nxt_s.busy = 1'b0;
      nxt_s.sus_tmr = '0;
      nxt_s.pd = 1'b0;
      nxt_s.pd_tmr = '0;
    end
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      s_ff <= D_RST;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign LNK.d_out = s_ff.dout;
  assign LNK.d_oe_n = s_ff.doe_n;
  assign BUSY = s_ff.busy;
  assign SUSPENDED = s_ff.suspend_status_flag;
  assign POWER_DOWN = s_ff.pd;
  assign SUSPEND_REQ = s_ff.sus_req;
  assign RESUME_REQ = s_ff.res_req;
endmodule

/* File: frp_pkg.sv */
// shared constants for the flash resume, power-down and id command link
// Overview of operation
// - resume accepted only when suspended and idle
// - accepted resume clears suspend, raises busy quickly
// - resume otherwise ignored without any state change
// - power loss drops suspend, later resume ignored
// - host waits guard time before next suspend
// - select must rise right after eighth bit
// - power-down entered within entry time after select
// - in power-down only release code is recognised
// - device starts in normal operation after reset
// - release returns to normal after recovery time
// - host holds select high during recovery time
// - id code gives device byte after three dummies
// - device byte repeats until select rises
// - release/id ignored while busy
// - single id read: code, zero address, two bytes
// - dual id read: two bits per clock
// - address one gives device byte first, alternating
// - quad id read: four dummies, four bits per clock
// - host sends mode bits with upper nibble F
// - accepted suspend sets flag, clears busy later
package frp_pkg;
  localparam int CLK_NS = 10;
  localparam logic [7:0] OP_RESUME = 8'h7A;
  localparam logic [7:0] OP_SUSPEND = 8'h75;
  localparam logic [7:0] OP_PDOWN = 8'hB9;
  localparam logic [7:0] OP_REL_ID = 8'hAB;
  localparam logic [7:0] OP_MFR_ID = 8'h90;
  localparam logic [7:0] OP_ID_DUAL = 8'h92;
  localparam logic [7:0] OP_ID_QUAD = 8'h94;
  localparam logic [7:0] MODE_BITS = 8'hF0;
  localparam logic [7:0] CMD_CLKS = 8'h08;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  // header clocks after the command byte, seen from the host
  localparam logic [7:0] HDR_CLK_SGL = 8'h18;
  localparam logic [7:0] HDR_CLK_DUAL = 8'h10;
  localparam logic [7:0] HDR_CLK_QUAD = 8'h0C;
  // last header clock index and address bit 0 clock index, device view
  localparam logic [4:0] HDR_LAST_SGL = 5'h17;
  localparam logic [4:0] HDR_LAST_DUAL = 5'h0F;
  localparam logic [4:0] HDR_LAST_QUAD = 5'h0B;
  localparam logic [4:0] A0_AT_DUAL = 5'h0B;
  localparam logic [4:0] A0_AT_QUAD = 5'h09;
  localparam int TMR_W = 12;
  localparam int SUS_GUARD_NS = 20000;
  localparam logic [TMR_W-1:0] SUS_GUARD_CYC = TMR_W'(SUS_GUARD_NS / CLK_NS);
  localparam int PD_ENTER_NS = 3000;
  localparam logic [TMR_W-1:0] PD_ENTER_CYC = TMR_W'(PD_ENTER_NS / CLK_NS);
  localparam int PD_EXIT_NS = 3000;
  localparam logic [TMR_W-1:0] PD_EXIT_CYC = TMR_W'((PD_EXIT_NS + CLK_NS - 1) / CLK_NS);
  localparam int SCK_HALF_CYC = 4;
  localparam logic [3:0] LANES_OFF = 4'hF;
endpackage

/* File: frp_if.sv */
// link between host and flash ends: clock, select and four data lanes
interface frp_if;
  logic sclk;
  logic cs_n;
  logic [3:0] h_out;
  logic [3:0] h_oe_n;
  logic [3:0] d_out;
  logic [3:0] d_oe_n;
  logic [3:0] io;
  // undriven lanes float high through pull-ups
  assign io = (~d_oe_n & d_out) | (d_oe_n & ~h_oe_n & h_out) | (d_oe_n & h_oe_n);
  modport dev (input sclk, input cs_n, input io, output d_out, output d_oe_n);
  modport host (output sclk, output cs_n, output h_out, output h_oe_n, input io);
endinterface

/* File: frp_sync.sv */
// two-stage synchroniser for link pins
module frp_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] sync;
  } frp_sy_t;
  frp_sy_t q_ff;
  frp_sy_t nxt_q;
  always_comb begin
    nxt_q.meta = d;
    nxt_q.sync = q_ff.meta;
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q_ff <= '{meta: RST_VAL, sync: RST_VAL};
    end else begin
      q_ff <= nxt_q;
    end
  end
  assign q = q_ff.sync;
endmodule

/* File: frp_host.sv */
// host end: frames commands, makes the serial clock and collects id bytes
module frp_host #(
  parameter int HALF = frp_pkg::SCK_HALF_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RST,
  frp_if.host LNK,
  input wire logic CMD_VALID,
  output logic CMD_READY,
  input wire logic [7:0] CMD_OP,
  input wire logic [23:0] CMD_ADDR,
  input wire logic [3:0] CMD_RDLEN,
  output logic RD_VALID,
  output logic [7:0] RD_DATA
);
  typedef enum logic [1:0] {H_IDLE, H_XFER, H_GAP} frp_hst_t;
  typedef struct packed {
    frp_hst_t st;
    logic sclk;
    logic cs_n;
    logic [3:0] div;
    logic [7:0] ccnt;
    logic [7:0] hend;
    logic [7:0] tot;
    logic [3:0] w;
    logic [7:0] op;
    logic [7:0] opsr;
    logic [47:0] tx;
    logic [3:0] hout;
    logic [3:0] hoe_n;
    logic [7:0] rx;
    logic [3:0] rbits;
    logic rd_v;
    logic [7:0] rd_d;
    logic [frp_pkg::TMR_W-1:0] gap;
    logic [frp_pkg::TMR_W-1:0] guard;
  } frp_hstate_t;
  localparam frp_hstate_t H_RST = '{st: H_IDLE, cs_n: 1'b1, hoe_n: frp_pkg::LANES_OFF,
                                    default: '0};
  frp_hstate_t h_ff;
  frp_hstate_t nxt_h;
  logic [3:0] io_q;

  frp_sync #(.W(4), .RST_VAL(4'hF)) u_sync (
    .clk(SYS_CLK),
    .rst(RST),
    .d(LNK.io),
    .q(io_q)
  );

  // a suspend is held off until the guard after a resume has run out
  assign CMD_READY = (h_ff.st == H_IDLE) &&
                     !(CMD_OP == frp_pkg::OP_SUSPEND && h_ff.guard != '0);

  always_comb begin
    logic [7:0] k;
    logic [7:0] hc;
    logic [7:0] rc;
    logic [7:0] rx_nx;
    nxt_h = h_ff;
    k = h_ff.ccnt + 8'h01;
    hc = 8'h00;
    rc = 8'h00;
    rx_nx = 8'h00;
    nxt_h.rd_v = 1'b0;
    if (h_ff.guard != '0) begin
      nxt_h.guard = h_ff.guard - 1'b1;
    end
    case (h_ff.st)
      H_IDLE: begin
        if (CMD_VALID && CMD_READY) begin
          nxt_h.op = CMD_OP;
          nxt_h.opsr = {CMD_OP[6:0], 1'b0};
          nxt_h.w = 4'h1;
          nxt_h.tx = '0;
          case (CMD_OP)
            frp_pkg::OP_MFR_ID: begin
              hc = frp_pkg::HDR_CLK_SGL;
              rc = {1'b0, CMD_RDLEN, 3'h0};
              nxt_h.tx = {CMD_ADDR, 24'h00_0000};
            end
            frp_pkg::OP_ID_DUAL: begin
              nxt_h.w = 4'h2;
              hc = frp_pkg::HDR_CLK_DUAL;
              rc = {2'b00, CMD_RDLEN, 2'b00};
              nxt_h.tx = {CMD_ADDR, frp_pkg::MODE_BITS, 16'h0000};
            end
            frp_pkg::OP_ID_QUAD: begin
              nxt_h.w = 4'h4;
              hc = frp_pkg::HDR_CLK_QUAD;
              rc = {3'b000, CMD_RDLEN, 1'b0};
              nxt_h.tx = {16'h0000, CMD_ADDR, frp_pkg::MODE_BITS};
            end
            frp_pkg::OP_REL_ID: begin
              hc = (CMD_RDLEN != 4'h0) ? frp_pkg::HDR_CLK_SGL : 8'h00;
              rc = {1'b0, CMD_RDLEN, 3'h0};
            end
            default: begin
            end
          endcase
          // plain commands end after the eighth clock
          nxt_h.hend = frp_pkg::CMD_CLKS + hc;
          nxt_h.tot = frp_pkg::CMD_CLKS + hc + rc;
          nxt_h.st = H_XFER;
          nxt_h.cs_n = 1'b0;
          nxt_h.sclk = 1'b0;
          nxt_h.div = 4'(HALF - 1);
          nxt_h.ccnt = 8'h00;
          nxt_h.rbits = 4'h0;
          nxt_h.hout = {3'b000, CMD_OP[7]};
          nxt_h.hoe_n = 4'hE;
        end
      end
      H_XFER: begin
        if (h_ff.div != 4'h0) begin
          nxt_h.div = h_ff.div - 4'h1;
        end else begin
          nxt_h.div = 4'(HALF - 1);
          nxt_h.sclk = ~h_ff.sclk;
          if (h_ff.sclk) begin
            nxt_h.ccnt = k;
            if (h_ff.ccnt >= h_ff.hend) begin
              // bits driven at the previous fall are taken at this one
              case (h_ff.w)
                4'h4: rx_nx = {h_ff.rx[3:0], io_q};
                4'h2: rx_nx = {h_ff.rx[5:0], io_q[1:0]};
                default: rx_nx = {h_ff.rx[6:0], io_q[1]};
              endcase
              nxt_h.rx = rx_nx;
              nxt_h.rbits = h_ff.rbits + h_ff.w;
              if (h_ff.rbits + h_ff.w == frp_pkg::BYTE_BITS) begin
                nxt_h.rbits = 4'h0;
                nxt_h.rd_v = 1'b1;
                nxt_h.rd_d = rx_nx;
              end
            end
            if (k == h_ff.tot) begin
              nxt_h.st = H_GAP;
              nxt_h.cs_n = 1'b1;
              nxt_h.hoe_n = frp_pkg::LANES_OFF;
              nxt_h.gap = frp_pkg::TMR_W'(HALF);
              if (h_ff.op == frp_pkg::OP_REL_ID) begin
                nxt_h.gap = frp_pkg::PD_EXIT_CYC;
              end
              if (h_ff.op == frp_pkg::OP_RESUME) begin
                nxt_h.guard = frp_pkg::SUS_GUARD_CYC;
              end
            end else if (k < frp_pkg::CMD_CLKS) begin
              nxt_h.hout = {3'b000, h_ff.opsr[7]};
              nxt_h.opsr = {h_ff.opsr[6:0], 1'b0};
            end else if (k < h_ff.hend) begin
              case (h_ff.w)
                4'h4: begin
                  nxt_h.hout = h_ff.tx[47:44];
                  nxt_h.hoe_n = 4'h0;
                end
                4'h2: begin
                  nxt_h.hout = {2'b00, h_ff.tx[47:46]};
                  nxt_h.hoe_n = 4'hC;
                end
                default: begin
                  nxt_h.hout = {3'b000, h_ff.tx[47]};
                  nxt_h.hoe_n = 4'hE;
                end
              endcase
              nxt_h.tx = 48'(h_ff.tx << h_ff.w);
            end else begin
              nxt_h.hoe_n = frp_pkg::LANES_OFF;
            end
          end
        end
      end
      H_GAP: begin
        if (h_ff.gap != '0) begin
          nxt_h.gap = h_ff.gap - 1'b1;
        end else begin
          nxt_h.st = H_IDLE;
        end
      end
      default: begin
        nxt_h.st = H_IDLE;
      end
    endcase
  end

  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      h_ff <= H_RST;
    end else begin
      h_ff <= nxt_h;
    end
  end

  assign LNK.sclk = h_ff.sclk;
  assign LNK.cs_n = h_ff.cs_n;
  assign LNK.h_out = h_ff.hout;
  assign LNK.h_oe_n = h_ff.hoe_n;
  assign RD_VALID = h_ff.rd_v;
  assign RD_DATA = h_ff.rd_d;
endmodule

/* File: frp_asserts.sv */
// checker: timing and order of the link and of the flash end
module frp_asserts (
  input logic SYS_CLK,
  input logic RST,
  input logic sclk,
  input logic cs_n,
  input logic [3:0] h_oe_n,
  input logic [3:0] d_oe_n,
  input logic BUSY,
  input logic SUSPENDED,
  input logic POWER_DOWN,
  input logic POWER_LOSS
);
  timeunit 1ns;
  timeprecision 100ps;
  typedef struct packed {
    logic [11:0] hi;
    logic [11:0] bh;
    logic [7:0] clks;
    logic [7:0] last;
    logic sk;
  } frp_chk_t;
  frp_chk_t st_ff, nxt_st;
  // hi: cycles since select rose, bh: cycles suspended while busy, last: clocks of last frame
  always_comb begin
    nxt_st = st_ff;
    nxt_st.sk = sclk;
    nxt_st.hi = !cs_n ? 12'h000 : (&st_ff.hi) ? st_ff.hi : st_ff.hi + 12'h001;
    nxt_st.bh = (SUSPENDED && BUSY) ? st_ff.bh + 12'h001 : 12'h000;
    if (!cs_n && sclk && !st_ff.sk) begin
      nxt_st.clks = st_ff.clks + 8'h01;
    end
    if (cs_n) begin
      nxt_st.clks = 8'h00;
      if (st_ff.clks != 8'h00) begin
        nxt_st.last = st_ff.clks;
      end
    end
  end
  always_ff @(posedge SYS_CLK or posedge RST) begin
    if (RST) begin
      st_ff <= '0;
    end else begin
      st_ff <= nxt_st;
    end
  end
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (RST);
  a_idle_lanes_free: assert property (cs_n [*6] |-> d_oe_n == 4'hF && h_oe_n == 4'hF && !sclk)
    else $error("lanes driven or clock moving while deselected");
  a_no_lane_fight: assert property ((d_oe_n | h_oe_n) == 4'hF)
    else $error("host and flash drive one lane together");
  a_resume_busy_order: assert property ($fell(SUSPENDED) && !$past(POWER_LOSS) |-> BUSY && !$past(BUSY))
    else $error("resume taken while busy or busy not raised");
  a_suspend_needs_busy: assert property ($rose(SUSPENDED) |-> $past(BUSY) && BUSY)
    else $error("suspend taken while idle");
  a_guard_upper: assert property (st_ff.bh <= frp_pkg::SUS_GUARD_CYC + 12'h002)
    else $error("busy not cleared within guard time");
  a_guard_lower: assert property ($fell(BUSY) && SUSPENDED |-> st_ff.bh + 12'h002 >= frp_pkg::SUS_GUARD_CYC)
    else $error("busy cleared before guard time");
  a_pd_after_eight: assert property ($rose(POWER_DOWN) |-> st_ff.last == 8'h08 && cs_n)
    else $error("power-down after a frame not of eight clocks");
  a_pd_entry_time: assert property ($rose(POWER_DOWN) |-> st_ff.hi <= frp_pkg::PD_ENTER_CYC + 12'h008)
    else $error("power-down entered late");
  a_release_wait: assert property ($fell(POWER_DOWN) && !$past(POWER_LOSS) |-> st_ff.hi >= frp_pkg::PD_EXIT_CYC)
    else $error("power-down left before recovery time");
  a_pd_stays_quiet: assert property (POWER_DOWN && $past(POWER_DOWN) && !$past(POWER_LOSS) |-> $stable(SUSPENDED) && d_oe_n == 4'hF)
    else $error("flash acted while powered down");
  a_loss_clears_all: assert property (POWER_LOSS |=> !SUSPENDED && !BUSY && !POWER_DOWN)
    else $error("power loss left state behind");
  c_resume: cover property ($fell(SUSPENDED) && BUSY);
  c_pd_enter: cover property ($rose(POWER_DOWN));
  c_pd_leave: cover property ($fell(POWER_DOWN));
  c_quad_out: cover property (d_oe_n == 4'h0);
endmodule

/* File: frp_tb_top.sv */
// testbench: host and flash ends joined, plus a spare flash end driven bit by bit
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin err_total++; \
  $display("Error %s exp %h got %h", nm, e, g); end end
module frp_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  localparam logic [7:0] MFR = 8'hC3; // arbitrary value
  localparam logic [7:0] DEVB = 8'h4E; // arbitrary value
  logic SYS_CLK = 1'b0;
  logic RST = 1'b1;
  logic op_start = 1'b0, op_done = 1'b0, pwr_loss = 1'b0, cmd_valid = 1'b0;
  logic [7:0] cmd_op = 8'h00;
  logic [23:0] cmd_addr = 24'h00_0000;
  logic [3:0] cmd_rdlen = 4'h0;
  logic cmd_ready, rd_valid, busy, suspend_status_flag, pdn, pdn2, sus_req, res_req;
  logic [7:0] rd_data, cap, e_b;
  logic [7:0] ops [3] = '{8'h90, 8'h92, 8'h94};
  logic [7:0] exp_q [$];
  integer seed = 30989;
  int err_total = 0, compares = 0, cyc = 0, nrise = 0, waited = 0;
  int m_busy = 0, m_sus = 0, m_pd = 0, n_sus = 0, n_res = 0;
  frp_if lnk();
  frp_if lnk2();
  frp_host frp_host_i (.SYS_CLK(SYS_CLK), .RST(RST), .LNK(lnk.host), .CMD_VALID(cmd_valid),
    .CMD_READY(cmd_ready), .CMD_OP(cmd_op), .CMD_ADDR(cmd_addr), .CMD_RDLEN(cmd_rdlen),
    .RD_VALID(rd_valid), .RD_DATA(rd_data));
  frp_dev #(.MFR_ID(MFR), .DEV_ID(DEVB)) frp_dev_i (.SYS_CLK(SYS_CLK), .RST(RST),
    .LNK(lnk.dev), .OP_START(op_start), .OP_DONE(op_done), .POWER_LOSS(pwr_loss),
    .BUSY(busy), .SUSPENDED(suspend_status_flag), .POWER_DOWN(pdn), .SUSPEND_REQ(sus_req),
    .RESUME_REQ(res_req));
  frp_dev frp_dev2_i (.SYS_CLK(SYS_CLK), .RST(RST), .LNK(lnk2.dev), .OP_START(op_start),
    .OP_DONE(op_done), .POWER_LOSS(pwr_loss), .BUSY(), .SUSPENDED(), .POWER_DOWN(pdn2),
    .SUSPEND_REQ(), .RESUME_REQ());
  frp_asserts frp_asserts_i (.SYS_CLK(SYS_CLK), .RST(RST), .sclk(lnk.sclk), .cs_n(lnk.cs_n),
    .h_oe_n(lnk.h_oe_n), .d_oe_n(lnk.d_oe_n), .BUSY(busy), .SUSPENDED(suspend_status_flag),
    .POWER_DOWN(pdn), .POWER_LOSS(pwr_loss));
  always #5 SYS_CLK = ~SYS_CLK;
  task automatic stop_test;
    $display("compares %0d mismatches %0d", compares, err_total);
    if (err_total == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  always @(posedge SYS_CLK) begin
    if (rd_valid === 1'b1) begin
      e_b = (exp_q.size() > 0) ? exp_q.pop_front() : 8'hxx;
      `CHK("id_byte", e_b, rd_data)
    end
    if (sus_req === 1'b1) n_sus++;
    if (res_req === 1'b1) n_res++;
    cyc++;
    if (cyc > 40000) begin
      err_total++;
      $display("Error cycle_limit exp %0d got %0d", 40000, cyc);
      stop_test();
    end
  end
  // command byte as seen on lane 0 at each rising serial clock
  always @(negedge lnk.cs_n) nrise = 0;
  always @(posedge lnk.sclk) begin
    if (lnk.cs_n === 1'b0) begin
      if (nrise < 8) cap = {cap[6:0], lnk.io[0]};
      nrise++;
    end
  end
  task automatic send(input logic [7:0] op, input logic [23:0] ad, input logic [3:0] n);
    int k;
    k = 0;
    waited = 0;
    @(posedge SYS_CLK);
    cmd_valid <= 1'b1;
    cmd_op <= op;
    cmd_addr <= ad;
    cmd_rdlen <= n;
    @(negedge SYS_CLK);
    while (cmd_ready !== 1'b1 && waited < 5000) begin
      waited++;
      @(negedge SYS_CLK);
    end
    @(posedge SYS_CLK);
    cmd_valid <= 1'b0;
    @(negedge SYS_CLK);
    while (cmd_ready !== 1'b1 && k < 5000) begin
      k++;
      @(negedge SYS_CLK);
    end
    `CHK("opcode_bits", op, cap)
    `CHK("bytes_left", 0, exp_q.size())
  endtask
  task automatic idrd(input logic [7:0] op, input logic [23:0] ad, input logic [3:0] n,
    input logic ok);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back(!ok ? 8'hFF : (op == 8'hAB || (i + ad[0]) % 2 == 1) ? DEVB : MFR);
    end
    send(op, ad, n);
  endtask
  task automatic chk_state;
    repeat (8) @(posedge SYS_CLK);
    `CHK("busy", m_busy[0], busy)
    `CHK("suspended", m_sus[0], suspend_status_flag)
    `CHK("power_down", m_pd[0], pdn)
  endtask
  task automatic wait_sig(input int sel, input logic v, input int lim);
    waited = 0;
    @(negedge SYS_CLK);
    while ((sel == 0 ? busy : sel == 1 ? pdn : pdn2) !== v && waited < lim) begin
      waited++;
      @(negedge SYS_CLK);
    end
  endtask
  task automatic pulse(input int sel);
    @(posedge SYS_CLK);
    if (sel == 0) op_start <= 1'b1;
    else if (sel == 1) op_done <= 1'b1;
    else pwr_loss <= 1'b1;
    @(posedge SYS_CLK);
    op_start <= 1'b0;
    op_done <= 1'b0;
    pwr_loss <= 1'b0;
  endtask
  // spare link: frames with a chosen clock count, extra bits sent as ones
  task automatic bb(input logic [7:0] op, input int nclk);
    @(posedge SYS_CLK);
    lnk2.cs_n <= 1'b0;
    lnk2.h_oe_n <= 4'hE;
    for (int i = 0; i < nclk; i++) begin
      lnk2.h_out <= {3'h7, (i < 8) ? op[7 - i] : 1'b1};
      repeat (4) @(posedge SYS_CLK);
      lnk2.sclk <= 1'b1;
      repeat (4) @(posedge SYS_CLK);
      lnk2.sclk <= 1'b0;
    end
    repeat (4) @(posedge SYS_CLK);
    lnk2.cs_n <= 1'b1;
    lnk2.h_oe_n <= 4'hF;
  endtask
  initial begin
    lnk2.sclk = 1'b0;
    lnk2.cs_n = 1'b1;
    lnk2.h_out = 4'hF;
    lnk2.h_oe_n = 4'hF;
    repeat (10) @(posedge SYS_CLK);
    RST <= 1'b0;
    chk_state();
    $display("test reset done");
    for (int a = 0; a < 2; a++) begin
      foreach (ops[j]) idrd(ops[j], 24'(a), 4'(1 + ($random(seed) & 3)), 1'b1);
    end
    idrd(8'hAB, 24'h00_0000, 4'(1 + ($random(seed) & 3)), 1'b1);
    $display("test id reads done");
    send(8'h7A, 24'h00_0000, 4'h0);
    chk_state();
    pulse(0);
    m_busy = 1;
    idrd(8'hAB, 24'h00_0000, 4'h2, 1'b0);
    send(8'h7A, 24'h00_0000, 4'h0);
    chk_state();
    send(8'h75, 24'h00_0000, 4'h0);
    m_sus = 1;
    chk_state();
    wait_sig(0, 1'b0, 2500);
    `CHK("guard_bound", 1'b1, waited < 2100)
    m_busy = 0;
    send(8'h7A, 24'h00_0000, 4'h0);
    m_sus = 0;
    m_busy = 1;
    chk_state();
    `CHK("resume_reqs", 1, n_res)
    send(8'h75, 24'h00_0000, 4'h0);
    `CHK("guard_hold", 1'b1, waited > 1000)
    m_sus = 1;
    wait_sig(0, 1'b0, 2500);
    m_busy = 0;
    chk_state();
    `CHK("suspend_reqs", 2, n_sus)
    pulse(2);
    m_sus = 0;
    send(8'h7A, 24'h00_0000, 4'h0);
    chk_state();
    $display("test resume done");
    send(8'hB9, 24'h00_0000, 4'h0);
    `CHK("frame_clocks", 8, nrise)
    wait_sig(1, 1'b1, 400);
    m_pd = 1;
    chk_state();
    idrd(8'h90, 24'h00_0000, 4'h2, 1'b0);
    send(8'h7A, 24'h00_0000, 4'h0);
    chk_state();
    send(8'hAB, 24'h00_0000, 4'h0);
    wait_sig(1, 1'b0, 400);
    m_pd = 0;
    chk_state();
    idrd(8'h90, 24'h00_0001, 4'h2, 1'b1);
    pulse(0);
    m_busy = 1;
    chk_state();
    pulse(1);
    m_busy = 0;
    chk_state();
    $display("test power-down done");
    bb(8'hB9, 9);
    wait_sig(2, 1'b1, 400);
    `CHK("pd_bad_frame", 1'b0, pdn2)
    bb(8'hB9, 8);
    wait_sig(2, 1'b1, 400);
    `CHK("pd_good_frame", 1'b1, pdn2)
    `CHK("resume_reqs_end", 1, n_res)
    `CHK("suspend_reqs_end", 2, n_sus)
    $display("test framing done");
    stop_test();
  end
endmodule
